// File: design/edge_timing.sv
// complementary output edge timing: phase, blanking and dead-band
`timescale 1ns/1ps

// What this block does
// [R1] falling dead-band counts chain periods when selected
// [R2] falling dead-band counts clock periods otherwise
// [R3] rising blanking ignores falling inputs for count
// [R4] falling blanking ignores rising inputs for count
// [R5] rising phase count postpones rising event
// [R6] falling phase count postpones falling event
// [R7] count registers upper nibble reads zero
// [R8] count fields undefined at power-on, never reset
// [R9] rising dead-band delays primary, timebase selectable
// [R10] zero count adds no delay or window
module edge_timing
  import edge_timing_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire wb_req_type wbReq,
  output logic [DATA_W-1:0] wbDatOut,
  output logic wbAck,
  input wire logic riseSrc,
  input wire logic fallSrc,
  output logic primaryOut,
  output logic complementaryOut
);

  // ==========================================================
  // declarations
  logic ack_reg;
  logic [DATA_W-1:0] rdat_reg;
  logic [1:0] tb_reg;
  logic [COUNT_W-1:0] count_reg [NUM_TIMERS];
  logic [1:0] syncA_reg;
  logic [1:0] syncB_reg;
  logic [1:0] syncC_reg;
  logic [1:0] filt_reg;
  logic [1:0] chainCnt_reg;
  logic chainTick_reg;
  logic primary_reg;
  logic comp_reg;
  logic busAccept;
  logic wrAccept;
  logic [1:0] srcEdge;
  logic riseAccept;
  logic fallAccept;
  logic [NUM_TIMERS-1:0] tStart;
  logic [NUM_TIMERS-1:0] tAbort;
  logic [NUM_TIMERS-1:0] tTick;
  logic [NUM_TIMERS-1:0] tDone;
  logic [NUM_TIMERS-1:0] tBusy;
  logic [NUM_TIMERS-1:0] regHit;
  logic [COUNT_W-1:0] countRead [NUM_TIMERS+1];
  logic hitTb;
  logic hitStatus;
  logic [7:0] readByte;
  logic [7:0] statusByte;

  // ==========================================================
  // wishbone slave: ack one cycle after the request, then drop
  assign busAccept = wbReq.cyc && wbReq.stb && !ack_reg;
  assign wrAccept = busAccept && wbReq.we && wbReq.sel[0];
  assign hitTb = (wbReq.adr == OFF_TIMEBASE);
  assign hitStatus = (wbReq.adr == OFF_STATUS);
  assign statusByte = {4'h0, tBusy[T_FALL_BLANK], tBusy[T_RISE_BLANK],
    comp_reg, primary_reg};
  // unmapped addresses answer with zero data
  assign readByte = hitTb ? {tb_reg, 6'h00} :
    hitStatus ? statusByte :
    {4'h0, countRead[NUM_TIMERS]}; // [R7]

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= busAccept;
      if (busAccept) begin
        rdat_reg <= {24'h00_0000, readByte}; // [R7]
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tb_reg <= TIMEBASE_RESET;
    end else if (wrAccept && hitTb) begin
      tb_reg <= {wbReq.dat[RISE_TB_BIT], wbReq.dat[FALL_TB_BIT]};
    end
  end

  assign wbAck = ack_reg;
  assign wbDatOut = rdat_reg;

  // ==========================================================
  // count registers: no reset, power-on value is unknown
  assign countRead[0] = 4'h0;
  generate
    for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_count
      assign regHit[i] = (wbReq.adr == TIMER_OFF[i]);
      assign countRead[i+1] = countRead[i] |
        ({COUNT_W{regHit[i]}} & count_reg[i]);
      // only the low nibble is stored; bits 7-4 are dropped
      always_ff @(posedge core_clk) begin // [R8]
        if (wrAccept && regHit[i]) begin
          count_reg[i] <= wbReq.dat[COUNT_W-1:0]; // [R7]
        end
      end
    end
  endgenerate

  // ==========================================================
  // event inputs: three flip-flops, change once second and third agree
  generate
    for (genvar j = 0; j < 2; j++) begin : g_sync
      assign srcEdge[j] = (syncB_reg[j] == syncC_reg[j]) &&
        syncC_reg[j] && !filt_reg[j];
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          syncA_reg[j] <= 1'b0;
          syncB_reg[j] <= 1'b0;
          syncC_reg[j] <= 1'b0;
          filt_reg[j] <= 1'b0;
        end else begin
          syncA_reg[j] <= (j == 0) ? riseSrc : fallSrc;
          syncB_reg[j] <= syncA_reg[j];
          syncC_reg[j] <= syncB_reg[j];
          if (syncB_reg[j] == syncC_reg[j]) begin
            filt_reg[j] <= syncC_reg[j];
          end
        end
      end
    end
  endgenerate

  // blanking only suppresses the opposite edge, never its own
  assign riseAccept = srcEdge[0] && !tBusy[T_FALL_BLANK]; // [R4]
  assign fallAccept = srcEdge[1] && !tBusy[T_RISE_BLANK]; // [R3]

  // ==========================================================
  // delay-chain element emulated by a divided tick
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chainCnt_reg <= CHAIN_CNT_RESET;
      chainTick_reg <= 1'b0;
    end else begin
      chainTick_reg <= (chainCnt_reg == CHAIN_DIV_LAST);
      chainCnt_reg <= (chainCnt_reg == CHAIN_DIV_LAST) ?
        CHAIN_CNT_RESET : chainCnt_reg + 2'h1;
    end
  end

  // ==========================================================
  // timer wiring
  assign tStart[T_RISE_PHASE] = riseAccept; // [R5]
  assign tStart[T_FALL_PHASE] = fallAccept; // [R6]
  assign tStart[T_RISE_BLANK] = riseAccept; // [R3]
  assign tStart[T_FALL_BLANK] = fallAccept; // [R4]
  assign tStart[T_RISE_DB] = tDone[T_RISE_PHASE]; // [R9]
  assign tStart[T_FALL_DB] = tDone[T_FALL_PHASE]; // [R2]
  // an opposite event cancels a dead-band still running
  assign tAbort[T_RISE_DB] = tDone[T_FALL_PHASE];
  assign tAbort[T_FALL_DB] = tDone[T_RISE_PHASE];
  assign tAbort[T_RISE_PHASE] = 1'b0;
  assign tAbort[T_FALL_PHASE] = 1'b0;
  assign tAbort[T_RISE_BLANK] = 1'b0;
  assign tAbort[T_FALL_BLANK] = 1'b0;
  assign tTick[T_RISE_DB] = tb_reg[1] ? chainTick_reg : 1'b1; // [R9]
  assign tTick[T_FALL_DB] = tb_reg[0] ? chainTick_reg : 1'b1; // [R1]
  assign tTick[T_RISE_PHASE] = 1'b1;
  assign tTick[T_FALL_PHASE] = 1'b1;
  assign tTick[T_RISE_BLANK] = 1'b1;
  assign tTick[T_FALL_BLANK] = 1'b1;

  generate
    for (genvar k = 0; k < NUM_TIMERS; k++) begin : g_timer
      count_timer u_timer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .start(tStart[k]),
        .abort(tAbort[k]),
        .tickEn(tTick[k]),
        .count(count_reg[k]),
        .done(tDone[k]),
        .busy(tBusy[k])
      );
    end
  endgenerate

  // ==========================================================
  // outputs: the leaving output turns off at once, the other waits
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      primary_reg <= 1'b0;
      comp_reg <= 1'b0;
    end else begin
      if (tDone[T_FALL_PHASE]) begin
        primary_reg <= 1'b0; // [R6]
      end else if (tDone[T_RISE_DB]) begin
        primary_reg <= 1'b1; // [R9]
      end
      if (tDone[T_RISE_PHASE]) begin
        comp_reg <= 1'b0; // [R5]
      end else if (tDone[T_FALL_DB]) begin
        comp_reg <= 1'b1; // [R2]
      end
    end
  end

  assign primaryOut = primary_reg;
  assign complementaryOut = comp_reg;

  // ==========================================================
  // checks
  property p_upper_zero;
    @(posedge core_clk) disable iff (!reset_n)
      busAccept && !wbReq.we && (|regHit) |=> wbDatOut[31:4] == 28'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) // [R7]
    else $error("count register read upper bits not zero");

  property p_rise_blank;
    @(posedge core_clk) disable iff (!reset_n)
      tBusy[T_RISE_BLANK] |-> !tStart[T_FALL_PHASE];
  endproperty
  a_rise_blank: assert property (p_rise_blank) // [R3]
    else $error("falling event taken inside rising blank");

  property p_fall_blank;
    @(posedge core_clk) disable iff (!reset_n)
      tBusy[T_FALL_BLANK] |-> !tStart[T_RISE_PHASE];
  endproperty
  a_fall_blank: assert property (p_fall_blank) // [R4]
    else $error("rising event taken inside falling blank");

  property p_rise_phase;
    @(posedge core_clk) disable iff (!reset_n)
      tDone[T_RISE_PHASE] |=> !complementaryOut;
  endproperty
  a_rise_phase: assert property (p_rise_phase) // [R5]
    else $error("complementary still high after rising event");

  property p_fall_phase;
    @(posedge core_clk) disable iff (!reset_n)
      tDone[T_FALL_PHASE] |=> !primaryOut;
  endproperty
  a_fall_phase: assert property (p_fall_phase) // [R6]
    else $error("primary still high after falling event");

  property p_fall_chain;
    @(posedge core_clk) disable iff (!reset_n)
      tDone[T_FALL_DB] && tb_reg[0] && !$past(tStart[T_FALL_DB])
        |-> $past(chainTick_reg);
  endproperty
  a_fall_chain: assert property (p_fall_chain) // [R1]
    else $error("falling dead-band ended off a chain tick");

  property p_fall_dead;
    @(posedge core_clk) disable iff (!reset_n)
      tDone[T_FALL_DB] && !tDone[T_RISE_PHASE] |=> complementaryOut;
  endproperty
  a_fall_dead: assert property (p_fall_dead) // [R2]
    else $error("complementary not raised after dead-band");

  property p_rise_dead;
    @(posedge core_clk) disable iff (!reset_n)
      tDone[T_RISE_DB] && !tDone[T_FALL_PHASE] |=> primaryOut;
  endproperty
  a_rise_dead: assert property (p_rise_dead) // [R9]
    else $error("primary not raised after dead-band");

  property p_zero_path;
    @(posedge core_clk) disable iff (!reset_n)
      riseAccept && count_reg[T_RISE_PHASE] == 4'h0 |=> tDone[T_RISE_PHASE];
  endproperty
  a_zero_path: assert property (p_zero_path) // [R10]
    else $error("zero phase count added delay");

  // ==========================================================
  // blank window model: cycles since the last accepted event
  // saturates so a long idle spell never wraps into a false window
  logic [COUNT_W:0] riseAge;
  logic [COUNT_W:0] fallAge;
  logic [COUNT_W-1:0] riseWin;
  logic [COUNT_W-1:0] fallWin;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      riseAge <= 5'h1f;
      fallAge <= 5'h1f;
      riseWin <= 4'h0;
      fallWin <= 4'h0;
    end else begin
      if (riseAccept) begin
        riseAge <= 5'h00;
        riseWin <= count_reg[T_RISE_BLANK];
      end else if (riseAge != 5'h1f) begin
        riseAge <= riseAge + 5'h01;
      end
      if (fallAccept) begin
        fallAge <= 5'h00;
        fallWin <= count_reg[T_FALL_BLANK];
      end else if (fallAge != 5'h1f) begin
        fallAge <= fallAge + 5'h01;
      end
    end
  end

  property p_rise_window;
    @(posedge core_clk) disable iff (!reset_n)
      tBusy[T_RISE_BLANK] == ({1'b0, riseWin} > riseAge);
  endproperty
  a_rise_window: assert property (p_rise_window) // [R3]
    else $error("rising blank window length differs from count");

  property p_fall_window;
    @(posedge core_clk) disable iff (!reset_n)
      tBusy[T_FALL_BLANK] == ({1'b0, fallWin} > fallAge);
  endproperty
  a_fall_window: assert property (p_fall_window) // [R4]
    else $error("falling blank window length differs from count");

endmodule

// File: design/edge_timing_pkg.sv
// shared constants and types for the complementary output edge timing block
package edge_timing_pkg;

  // ==========================================================
  // bus and field layout
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 4;
  localparam logic [ADDR_W-1:0] OFF_FALL_DB = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_RISE_BLANK = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FALL_BLANK = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RISE_PHASE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_FALL_PHASE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_RISE_DB = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_TIMEBASE = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1c;

  // timebase register: bit 7 rising select, bit 6 falling select
  localparam int RISE_TB_BIT = 7;
  localparam int FALL_TB_BIT = 6;
  localparam logic [1:0] TIMEBASE_RESET = 2'h0;

  // status register bit positions
  localparam int ST_PRIMARY = 0;
  localparam int ST_COMPLEMENTARY = 1;
  localparam int ST_RISE_BLANK = 2;
  localparam int ST_FALL_BLANK = 3;

  // ==========================================================
  // timer slots
  localparam int T_RISE_PHASE = 0;
  localparam int T_FALL_PHASE = 1;
  localparam int T_RISE_BLANK = 2;
  localparam int T_FALL_BLANK = 3;
  localparam int T_RISE_DB = 4;
  localparam int T_FALL_DB = 5;
  localparam int NUM_TIMERS = 6;
  localparam logic [ADDR_W-1:0] TIMER_OFF [NUM_TIMERS] = '{
    OFF_RISE_PHASE, OFF_FALL_PHASE, OFF_RISE_BLANK,
    OFF_FALL_BLANK, OFF_RISE_DB, OFF_FALL_DB};

  // delay-chain element period: one tick every two core cycles
  localparam logic [1:0] CHAIN_DIV_LAST = 2'h1;
  localparam logic [1:0] CHAIN_CNT_RESET = 2'h0;

  // ==========================================================
  // wishbone request carrier
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [DATA_W-1:0] dat;
  } wb_req_type;

endpackage

// File: design/count_timer.sv
// one loadable down-counter with done pulse and busy level
`timescale 1ns/1ps
module count_timer
  import edge_timing_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic abort,
  input wire logic tickEn,
  input wire logic [COUNT_W-1:0] count,
  output logic done,
  output logic busy
);

  // ==========================================================
  // counter
  logic [COUNT_W-1:0] remain_reg;
  logic [COUNT_W-1:0] remain_next;
  logic done_reg;
  logic done_next;

  assign busy = (remain_reg != 4'h0);
  assign done = done_reg;
  // abort wins so a cancelled delay never fires late
  assign remain_next = abort ? 4'h0 : start ? count :
    (busy && tickEn) ? remain_reg - 4'h1 : remain_reg;
  assign done_next = !abort && ((start && count == 4'h0) || // [R10]
    (!start && busy && tickEn && remain_reg == 4'h1));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      remain_reg <= 4'h0;
      done_reg <= 1'b0;
    end else begin
      remain_reg <= remain_next;
      done_reg <= done_next;
    end
  end

  // ==========================================================
  // checks: ticks seen between load and done equal the count
  logic [COUNT_W:0] ticksSeen;
  logic [COUNT_W-1:0] loadedCount;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ticksSeen <= 5'h00;
      loadedCount <= 4'h0;
    end else if (start) begin
      ticksSeen <= 5'h00;
      loadedCount <= count;
    end else if (busy && tickEn) begin
      ticksSeen <= ticksSeen + 5'h01;
    end
  end

  sequence s_zero_load;
    start && !abort && count == 4'h0;
  endsequence

  property p_zero_immediate;
    @(posedge core_clk) disable iff (!reset_n)
      s_zero_load |=> done && !busy;
  endproperty
  a_zero_immediate: assert property (p_zero_immediate) // [R10]
    else $error("zero count did not finish in one cycle");

  property p_length;
    @(posedge core_clk) disable iff (!reset_n)
      done |-> ticksSeen == {1'b0, loadedCount};
  endproperty
  a_length: assert property (p_length) // [R5]
    else $error("timer length differs from loaded count");

endmodule

// File: verification/event_source.sv
// event source model driving the rising and falling event pins
`timescale 1ns/1ps
// ==========================================================
// event pins
module event_source (
  input wire logic core_clk,
  output logic riseSrc,
  output logic fallSrc
);
  initial begin
    riseSrc = 1'b0;
    fallSrc = 1'b0;
  end
  // held four cycles so the three-flop input filter always sees it
  task automatic fire(input logic fall, input int lead);
    repeat (lead) @(posedge core_clk);
    if (fall) fallSrc <= 1'b1;
    else riseSrc <= 1'b1;
    repeat (4) @(posedge core_clk);
    if (fall) fallSrc <= 1'b0;
    else riseSrc <= 1'b0;
  endtask
endmodule

// File: verification/test_edge_timing.sv
// self-checking bench for the complementary output edge timing block
`timescale 1ns/1ps
// ==========================================================
// bench top
module test_edge_timing;
  import edge_timing_pkg::*;
  logic core_clk, reset_n, wbAck, riseSrc, fallSrc;
  logic primaryOut, complementaryOut;
  wb_req_type wbReq;
  logic [DATA_W-1:0] wbDatOut, rd;
  int n_errors, check_count, r1, r2, f1, f2, a, b;

  edge_timing dut (.core_clk(core_clk), .reset_n(reset_n),
    .wbReq(wbReq), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .riseSrc(riseSrc), .fallSrc(fallSrc), .primaryOut(primaryOut),
    .complementaryOut(complementaryOut));
  event_source src (.core_clk(core_clk), .riseSrc(riseSrc),
    .fallSrc(fallSrc));

  always #20 core_clk = ~core_clk;

  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // wishbone classic cycle, entered just after a rising edge
  task automatic bus(input logic we, input logic [ADDR_W-1:0] adr,
                     input logic [DATA_W-1:0] dat);
    int k;
    wbReq <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hf, dat:dat};
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wbAck !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_errors++;
      complete_run();
    end
    rd = wbDatOut;
    wbReq <= '0;
    @(posedge core_clk);
  endtask

  task automatic cfg(input logic [23:0] v, input logic [7:0] tb);
    for (int i = 0; i < NUM_TIMERS; i++) bus(1'b1, TIMER_OFF[i],
      {28'h0, v[4*i +: 4]});
    bus(1'b1, OFF_TIMEBASE, {24'h0, tb});
  endtask

  // ==========================================================
  // one event; cycles until first and second output reach new level
  task automatic ev(input logic fall, output int t1, output int t2);
    t1 = -1;
    t2 = -1;
    fork
      src.fire(fall, 0);
      for (int k = 1; k <= 60 && t2 < 0; k++) begin
        @(posedge core_clk);
        if (t1 < 0 && (fall ? primaryOut : complementaryOut) === 1'b0)
          t1 = k;
        if ((fall ? complementaryOut : primaryOut) === 1'b1) t2 = k;
      end
    join
    if (t2 < 0) begin
      n_errors++;
      complete_run();
    end
    repeat (4) @(posedge core_clk);
  endtask

  // two opposite events one cycle apart, then the settled outputs
  task automatic pair(input logic fall);
    fork
      src.fire(fall, 0);
      src.fire(!fall, 1);
    join
    repeat (20) @(posedge core_clk);
  endtask

  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    wbReq = '0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    // ==========================================================
    // registers
    bus(1'b0, OFF_TIMEBASE, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < NUM_TIMERS; i++) begin
      bus(1'b1, TIMER_OFF[i], {28'hfffffff, 4'(i + 9)});
      bus(1'b0, TIMER_OFF[i], 32'h0);
      check(rd, {28'h0, 4'(i + 9)});
    end
    // counts survive a reset; only power-on leaves them unknown
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < NUM_TIMERS; i++) begin
      bus(1'b0, TIMER_OFF[i], 32'h0);
      check(rd, {28'h0, 4'(i + 9)});
    end
    bus(1'b1, 8'h20, 32'hffffffff);
    bus(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, OFF_TIMEBASE, 32'hc0);
    bus(1'b0, OFF_TIMEBASE, 32'h0);
    check(rd & 32'hc0, 32'hc0);
    // ==========================================================
    // edge timing, latencies relative to an all-zero baseline
    cfg(24'h0, 8'h0);
    ev(1'b1, a, b);
    ev(1'b0, r1, r2);
    check(32'(r2 - r1), 32'd1);
    ev(1'b1, f1, f2);
    check(32'(f2 - f1), 32'd1);
    cfg(24'h050000, 8'h0);
    ev(1'b0, a, b);
    check(32'(b), 32'(r2 + 5));
    cfg(24'h300000, 8'h0);
    ev(1'b1, a, b);
    check(32'(b), 32'(f2 + 3));
    // chain ticks are free running, so one cycle of slack either way
    cfg(24'h300000, 8'h40);
    ev(1'b0, a, b);
    ev(1'b1, a, b);
    check(32'(b - a >= 5 && b - a <= 7), 32'd1);
    cfg(24'h050000, 8'h80);
    ev(1'b0, a, b);
    check(32'(b - a >= 9 && b - a <= 11), 32'd1);
    ev(1'b1, a, b);
    cfg(24'h000034, 8'h0);
    ev(1'b0, a, b);
    check(32'(b), 32'(r2 + 4));
    ev(1'b1, a, b);
    check(32'(b), 32'(f2 + 3));
    // ==========================================================
    // blanking
    cfg(24'h000600, 8'h0);
    pair(1'b0);
    check({30'h0, primaryOut, complementaryOut}, 32'h2);
    ev(1'b1, a, b);
    cfg(24'h0, 8'h0);
    pair(1'b0);
    check({30'h0, primaryOut, complementaryOut}, 32'h1);
    cfg(24'h006000, 8'h0);
    ev(1'b0, a, b);
    pair(1'b1);
    check({30'h0, primaryOut, complementaryOut}, 32'h1);
    bus(1'b0, OFF_STATUS, 32'h0);
    check(rd & 32'h3, 32'h2);
    complete_run();
  end
endmodule
